// *** src/lpmsq_pkg.sv ***
// Shared constants and types of the low power mode sequencer
package lpmsq_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // Hold time is measured in millisecond ticks
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHORT_MIN_MS = 1000;
    localparam int SHORT_MAX_MS = 2000;
    localparam int LONG_MIN_MS = 3000;
    localparam int LONG_MAX_MS = 6000;
    localparam int HOLD_W = 13;
    localparam int SYNC_N = 3;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'h0,
        ST_SLEEP = 3'h1,
        ST_STBY = 3'h2,
        ST_SNOOZE = 3'h3,
        ST_DSTBY = 3'h4,
        ST_CLKSEL = 3'h5
    } lpmsq_state_t;

    localparam lpmsq_state_t STATE_RESET = ST_NORMAL;
    // Last entered reduced-power state after reset: next short press picks sleep, or standby in long-timer mode
    localparam lpmsq_state_t LAST_RESET = ST_DSTBY;
endpackage

// *** src/lpmsq_press.sv ***
// Button synchroniser and press-duration classifier
`timescale 1ns/10ps
module lpmsq_press
    import lpmsq_pkg::*;
#(
    parameter int TICK_N = TICK_CYCLES,
    parameter int SHORT_MIN = SHORT_MIN_MS,
    parameter int SHORT_MAX = SHORT_MAX_MS,
    parameter int LONG_MIN = LONG_MIN_MS,
    parameter int LONG_MAX = LONG_MAX_MS
) (
    input wire logic core_clk, // 100 MHz clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic button_n, // Push-button pin, low while pressed
    output logic press_done_r, // Pulse: a press was released
    output logic press_short_r, // Pulse: released inside the short window
    output logic press_long_r // Pulse: released inside the long window
);
    localparam int TW = $clog2(TICK_N + 1);
    localparam logic [HOLD_W-1:0] HOLD_SAT = HOLD_W'(LONG_MAX + 1);

    generate
        if (TICK_N < 1 || SHORT_MIN > SHORT_MAX || SHORT_MAX >= LONG_MIN || LONG_MIN > LONG_MAX
            || LONG_MAX + 1 >= (1 << HOLD_W)) begin : g_bad
            $error("lpmsq_press: press windows or tick length not servable");
        end
    endgenerate

    logic btn_meta_r;
    logic btn_sync_r;
    logic held_prev_r;
    logic [TW-1:0] tick_cnt_r;
    logic [HOLD_W-1:0] hold_ms_r;

    wire held = ~btn_sync_r;
    wire released = held_prev_r & ~held;
    wire tick = (tick_cnt_r == TW'(TICK_N - 1));
    wire in_short = (hold_ms_r >= HOLD_W'(SHORT_MIN))
        && (hold_ms_r <= HOLD_W'(SHORT_MAX));
    wire in_long = (hold_ms_r >= HOLD_W'(LONG_MIN))
        && (hold_ms_r <= HOLD_W'(LONG_MAX));

    always_ff @(posedge core_clk) begin
        if (rst) begin
            btn_meta_r <= 1'b1;
            btn_sync_r <= 1'b1;
            held_prev_r <= 1'b0;
        end else begin
            btn_meta_r <= button_n;
            btn_sync_r <= btn_meta_r;
            held_prev_r <= held;
        end
    end

    // Hold time saturates just past the long window so overlong presses stay unclassified
    always_ff @(posedge core_clk) begin
        if (rst || !held) begin
            tick_cnt_r <= '0;
            hold_ms_r <= '0;
        end else begin
            tick_cnt_r <= tick ? '0 : tick_cnt_r + TW'(1);
            if (tick && hold_ms_r != HOLD_SAT) begin
                hold_ms_r <= hold_ms_r + HOLD_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            press_done_r <= 1'b0;
            press_short_r <= 1'b0;
            press_long_r <= 1'b0;
        end else begin
            press_done_r <= released;
            press_short_r <= released & in_short;
            press_long_r <= released & in_long;
        end
    end
endmodule

// *** src/lpmsq_sequencer.sv ***
// Low power mode sequencer: button and timer driven reduced-power state machine
`timescale 1ns/10ps
module lpmsq_sequencer
    import lpmsq_pkg::*;
#(
    parameter int TICK_N = TICK_CYCLES
) (
    input wire logic core_clk, // 100 MHz clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic button_n, // Push-button pin, low while pressed
    input wire logic wake_timer_evt, // Periodic wake-timer pin, rising edge is an event
    input wire logic timer_underflow_event, // Channel one underflow pin, rising edge
    input wire logic long_timer_mode, // Pin level: long-timer variant selected
    input wire logic clk_sel_done, // Pulse from clock-selection machine, same clock
    output lpmsq_state_t mode_r, // Current power state
    output logic clk_sel_start_r, // Pulse: control passed to clock selection
    output logic dev_reset_req_r // Pulse: full device reset requested
);
    logic press_done;
    logic press_short;
    logic press_long;

    lpmsq_press #(
        .TICK_N(TICK_N)
    ) u_press (
        .core_clk(core_clk),
        .rst(rst),
        .button_n(button_n),
        .press_done_r(press_done),
        .press_short_r(press_short),
        .press_long_r(press_long)
    );

    // Pin synchronisers: meta, sync, and a third stage for edge detection
    logic [SYNC_N-1:0] pin_in;
    logic [SYNC_N-1:0] meta_r;
    logic [SYNC_N-1:0] sync_r;
    logic [SYNC_N-1:0] prev_r;
    logic [SYNC_N-1:0] rise;
    assign pin_in = {long_timer_mode, timer_underflow_event, wake_timer_evt};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    meta_r[gi] <= 1'b0;
                    sync_r[gi] <= 1'b0;
                    prev_r[gi] <= 1'b0;
                end else begin
                    meta_r[gi] <= pin_in[gi];
                    sync_r[gi] <= meta_r[gi];
                    prev_r[gi] <= sync_r[gi];
                end
            end
            assign rise[gi] = sync_r[gi] & ~prev_r[gi];
        end
    endgenerate

    wire wake_ev = rise[0];
    wire uflow_ev = rise[1];
    wire lt_mode = sync_r[2];

    lpmsq_state_t last_r;
    lpmsq_state_t state_nxt;
    lpmsq_state_t last_nxt;
    logic clk_start_nxt;
    logic reset_req_nxt;

    // Rotation target for the next short press
    lpmsq_state_t rot_next;
    assign rot_next = (last_r == ST_SLEEP) ? ST_STBY :
                      (last_r == ST_STBY) ? ST_SNOOZE :
                      (last_r == ST_SNOOZE) ? ST_DSTBY : ST_SLEEP;
    lpmsq_state_t lt_next;
    assign lt_next = (last_r == ST_STBY) ? ST_DSTBY : ST_STBY;
    // Wake sources differ between the two variants
    wire stby_wake = lt_mode ? uflow_ev : wake_ev;
    wire dstby_wake = lt_mode ? uflow_ev : press_done;

    always_comb begin
        state_nxt = mode_r;
        last_nxt = last_r;
        clk_start_nxt = 1'b0;
        reset_req_nxt = 1'b0;
        case (mode_r)
            ST_NORMAL: begin
                if (lt_mode) begin
                    if (press_done) begin
                        state_nxt = lt_next;
                        last_nxt = lt_next;
                    end
                end else if (press_short) begin
                    state_nxt = rot_next;
                    last_nxt = rot_next;
                end else if (press_long) begin
                    state_nxt = ST_CLKSEL;
                    clk_start_nxt = 1'b1;
                end
            end
            ST_SLEEP: begin
                if (press_done) begin
                    state_nxt = ST_NORMAL;
                end
            end
            ST_STBY, ST_SNOOZE: begin
                if (stby_wake) begin
                    state_nxt = ST_NORMAL;
                end
            end
            ST_DSTBY: begin
                if (dstby_wake) begin
                    state_nxt = ST_NORMAL;
                    last_nxt = LAST_RESET;
                    reset_req_nxt = 1'b1;
                end
            end
            ST_CLKSEL: begin
                if (clk_sel_done) begin
                    state_nxt = ST_NORMAL;
                end
            end
            default: begin
                state_nxt = ST_NORMAL;
            end
        endcase
    end

    // State, rotation memory and output pulses
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_r <= STATE_RESET;
            last_r <= LAST_RESET;
            clk_sel_start_r <= 1'b0;
            dev_reset_req_r <= 1'b0;
        end else begin
            mode_r <= state_nxt;
            last_r <= last_nxt;
            clk_sel_start_r <= clk_start_nxt;
            dev_reset_req_r <= reset_req_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // State machine checks
    sleep_exit_a: assert property ((mode_r == ST_SLEEP) && press_done
        |=> mode_r == ST_NORMAL)
        else $error("sleep not left on press");
    sleep_stay_a: assert property ((mode_r == ST_SLEEP) && !press_done
        |=> mode_r == ST_SLEEP)
        else $error("sleep left without press");
    deep_press_a: assert property ((mode_r == ST_DSTBY) && !lt_mode && press_done
        |=> (mode_r == ST_NORMAL) && dev_reset_req_r)
        else $error("press did not end deep standby with reset");
    short_enter_a: assert property ((mode_r == ST_NORMAL) && !lt_mode && press_short
        |=> mode_r inside {ST_SLEEP, ST_STBY, ST_SNOOZE, ST_DSTBY})
        else $error("short press did not enter low power");
    rotation_a: assert property ((mode_r == ST_NORMAL) && !lt_mode && press_short
        && (last_r == ST_SNOOZE) |=> mode_r == ST_DSTBY ##1 last_r == ST_DSTBY)
        else $error("rotation order broken");
    rot_start_a: assert property ((mode_r == ST_NORMAL) && !lt_mode && press_short
        && (last_r == ST_DSTBY) |=> (mode_r == ST_SLEEP) && (last_r == ST_SLEEP))
        else $error("rotation did not restart at sleep");
    clk_handoff_a: assert property ((mode_r == ST_NORMAL) && !lt_mode && press_long
        |=> (mode_r == ST_CLKSEL) && clk_sel_start_r ##1 !clk_sel_start_r)
        else $error("long press handoff wrong");
    clksel_hold_a: assert property ((mode_r == ST_CLKSEL) && !clk_sel_done
        |=> mode_r == ST_CLKSEL)
        else $error("clock selection left without done");
    button_ignored_a: assert property ((mode_r inside {ST_STBY, ST_SNOOZE})
        && press_done && !stby_wake |=> $stable(mode_r))
        else $error("button acted in standby");
    timer_wake_a: assert property ((mode_r inside {ST_STBY, ST_SNOOZE}) && !lt_mode
        && wake_ev |=> mode_r == ST_NORMAL)
        else $error("wake timer did not end standby");
    normal_quiet_a: assert property ((mode_r == ST_NORMAL) && !press_done
        |=> mode_r == ST_NORMAL)
        else $error("normal mode left without press");
    lt_first_a: assert property ((mode_r == ST_NORMAL) && lt_mode && press_done
        && (last_r != ST_STBY) |=> mode_r == ST_STBY)
        else $error("long-timer press did not enter standby");
    lt_deep_a: assert property ((mode_r == ST_NORMAL) && lt_mode && press_done
        && (last_r == ST_STBY) |=> mode_r == ST_DSTBY)
        else $error("long-timer press after standby not deep standby");
    lt_only_uflow_a: assert property ((mode_r inside {ST_STBY, ST_DSTBY}) && lt_mode
        && !uflow_ev |=> $stable(mode_r))
        else $error("standby left without underflow");
    uflow_wake_a: assert property ((mode_r inside {ST_STBY, ST_DSTBY}) && lt_mode
        && uflow_ev |=> mode_r == ST_NORMAL)
        else $error("underflow did not end standby");
    deep_reset_a: assert property ((mode_r == ST_DSTBY) ##1 (mode_r != ST_DSTBY)
        |-> dev_reset_req_r && $rose(dev_reset_req_r))
        else $error("deep standby left without reset request");
    reset_pulse_a: assert property (dev_reset_req_r |=> !dev_reset_req_r)
        else $error("reset request longer than one cycle");
    odd_press_a: assert property ((mode_r == ST_NORMAL) && !lt_mode && press_done
        && !press_short && !press_long |=> mode_r == ST_NORMAL && !clk_sel_start_r)
        else $error("unclassified press caused transition");

    // Scenario covers
    full_rotation_c: cover property ((mode_r == ST_SNOOZE) ##[1:1000] (mode_r == ST_NORMAL)
        ##[1:1000] (mode_r == ST_DSTBY));
    clk_handoff_c: cover property (clk_sel_start_r);
    deep_reset_c: cover property (dev_reset_req_r && lt_mode);
    sleep_trip_c: cover property ((mode_r == ST_SLEEP) ##1 (mode_r == ST_NORMAL));
    lt_standby_c: cover property (lt_mode && (mode_r == ST_STBY));
endmodule

// *** tb/lpmsq_partner.sv ***
// Model of the push-button and the two timer pins
`timescale 1ns/10ps
module lpmsq_partner (
    input wire logic core_clk, // 100 MHz clock
    output logic button_n, // Button pin, low while pressed
    output logic wake_timer_evt, // Wake-timer pin
    output logic timer_underflow_event // Underflow pin
);
    initial begin
        button_n = 1'b1;
        wake_timer_evt = 1'b0;
        timer_underflow_event = 1'b0;
    end
    // Hold low, then release back to the pull-up level
    task automatic press(input int cycles);
        @(posedge core_clk) button_n <= 1'b0;
        repeat (cycles) @(posedge core_clk);
        button_n <= 1'b1;
    endtask
    // Pins fall back low so that the next event is a fresh edge
    task automatic pulse(input bit unf);
        @(posedge core_clk);
        if (unf)
            timer_underflow_event <= 1'b1;
        else
            wake_timer_evt <= 1'b1;
        repeat (4) @(posedge core_clk);
        timer_underflow_event <= 1'b0;
        wake_timer_evt <= 1'b0;
    endtask
endmodule

// *** tb/tb.sv ***
// Testbench of the low power mode sequencer
`timescale 1ns/10ps
module tb;
    import lpmsq_pkg::*;
    localparam int TICK = 1;
    typedef struct {int kind; int ms; bit lt; lpmsq_state_t mode; int nrst; int nsel;} lpmsq_row_t;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic long_timer_mode = 1'b0;
    logic clk_sel_done = 1'b0;
    logic button_n, wake_timer_evt, timer_underflow_event;
    lpmsq_state_t mode_r;
    logic clk_sel_start_r, dev_reset_req_r;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int nrst = 0;
    int nsel = 0;
    // Kind: 0 press, 1 wake timer, 2 underflow
    lpmsq_row_t rows [25] = '{
        '{0, 500, 1, ST_STBY, 0, 0},
        '{0, 1500, 1, ST_STBY, 0, 0},
        '{1, 0, 1, ST_STBY, 0, 0},
        '{2, 0, 1, ST_NORMAL, 0, 0},
        '{0, 4500, 1, ST_DSTBY, 0, 0},
        '{0, 500, 1, ST_DSTBY, 0, 0},
        '{2, 0, 1, ST_NORMAL, 1, 0},
        '{0, 500, 0, ST_NORMAL, 1, 0},
        '{0, 2500, 0, ST_NORMAL, 1, 0},
        '{1, 0, 0, ST_NORMAL, 1, 0},
        '{2, 0, 0, ST_NORMAL, 1, 0},
        '{0, 1500, 0, ST_SLEEP, 1, 0},
        '{0, 4500, 0, ST_NORMAL, 1, 0},
        '{0, 1500, 0, ST_STBY, 1, 0},
        '{0, 1500, 0, ST_STBY, 1, 0},
        '{2, 0, 0, ST_STBY, 1, 0},
        '{1, 0, 0, ST_NORMAL, 1, 0},
        '{0, 1500, 0, ST_SNOOZE, 1, 0},
        '{0, 4500, 0, ST_SNOOZE, 1, 0},
        '{1, 0, 0, ST_NORMAL, 1, 0},
        '{0, 1500, 0, ST_DSTBY, 1, 0},
        '{0, 500, 0, ST_NORMAL, 2, 0},
        '{0, 7000, 0, ST_NORMAL, 2, 0},
        '{0, 4500, 0, ST_CLKSEL, 2, 1},
        '{0, 1500, 0, ST_CLKSEL, 2, 1}
    };
    lpmsq_partner u_partner (.core_clk(core_clk), .button_n(button_n),
        .wake_timer_evt(wake_timer_evt), .timer_underflow_event(timer_underflow_event));
    lpmsq_sequencer #(.TICK_N(TICK)) dut (.core_clk(core_clk), .rst(rst),
        .button_n(button_n), .wake_timer_evt(wake_timer_evt),
        .timer_underflow_event(timer_underflow_event), .long_timer_mode(long_timer_mode),
        .clk_sel_done(clk_sel_done), .mode_r(mode_r), .clk_sel_start_r(clk_sel_start_r),
        .dev_reset_req_r(dev_reset_req_r));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (dev_reset_req_r === 1'b1)
            nrst++;
        if (clk_sel_start_r === 1'b1)
            nsel++;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        foreach (rows[i]) begin
            long_timer_mode <= rows[i].lt;
            repeat (4) @(posedge core_clk);
            case (rows[i].kind)
                0: u_partner.press(rows[i].ms * TICK);
                1: u_partner.pulse(1'b0);
                2: u_partner.pulse(1'b1);
                default: ;
            endcase
            repeat (10) @(posedge core_clk);
            check(32'(mode_r), 32'(rows[i].mode));
            check(32'(nrst), 32'(rows[i].nrst));
            check(32'(nsel), 32'(rows[i].nsel));
            $display("Row %0d done", i);
        end
        @(posedge core_clk) clk_sel_done <= 1'b1;
        @(posedge core_clk) clk_sel_done <= 1'b0;
        repeat (3) @(posedge core_clk);
        check(32'(mode_r), 32'(ST_NORMAL));
        u_partner.press(1500 * TICK);
        repeat (10) @(posedge core_clk);
        check(32'(mode_r), 32'(ST_SLEEP));
        $display("Clock selection return done");
        // Reset in mid-run clears the rotation memory as well
        @(posedge core_clk) rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        check(32'(mode_r), 32'(STATE_RESET));
        check(32'(dev_reset_req_r), 32'h0);
        u_partner.press(1500 * TICK);
        repeat (10) @(posedge core_clk);
        check(32'(mode_r), 32'(ST_SLEEP));
        $display("Reset test done");
        stop_test();
    end
endmodule
